// *** pkg/rcr_pkg.sv ***
// Constants for the reset cause and memory remap block
// Contract
// - Every reset maps program memory at zero and clears the remap bit.
// - Setting the remap bit mirrors SRAM at address zero.
// - Clearing remap bit 0 restores program memory at address zero.
// - Vectors from zero to 0x20 come from the mirrored memory.
// - After reset execution starts in a hidden configuration kernel.
// - With boot mode pin high the kernel branches to vector zero.
// - Remap bit 4 is read-only; one means 32 kB program memory.
// - Remap bit 3 is read-only; one means 4 kB SRAM.
// - Power-on reset sets status bit 0.
// - Watchdog timeout reset sets status bit 1.
// - Writing one to status bit 2 forces a reset and stays set.
// - Status flags clear by ones written to the clear register; power-on reset also clears bits 1 and 2.
// - External pin reset leaves all status flags unchanged.
package rcr_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [31:0] REMAP_ADDR = 32'hFFFF0220;
    localparam logic [31:0] STATUS_ADDR = 32'hFFFF0230;
    localparam logic [31:0] CLEAR_ADDR = 32'hFFFF0234;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'hFFFF0240;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'hFFFF0244;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int REMAP_BIT = 0;
    localparam int SRAM_SMALL_BIT = 3;
    localparam int FLASH_SMALL_BIT = 4;
    localparam int POR_BIT = 0;
    localparam int WDT_BIT = 1;
    localparam int SW_BIT = 2;
    localparam int IRQ_WDT_BIT = 0;
    localparam int IRQ_EXT_BIT = 1;
    localparam int IRQ_BOOT_BIT = 2;
    localparam logic [2:0] STATUS_RESET = 3'h1;
    localparam logic [2:0] CLEAR_RESET = 3'h0;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam logic REMAP_RESET = 1'b0;
    localparam logic [31:0] VECTOR_TOP = 32'h00000020;
    localparam logic [31:0] RESET_VECTOR = 32'h00000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int RESET_HOLD_NS = 40;
    localparam int KERNEL_NS = 200;
    localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int KERNEL_CYCLES = (KERNEL_NS + CLK_NS - 1) / CLK_NS;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BOOT_RESET, BOOT_KERNEL, BOOT_USER, BOOT_DOWNLOAD
    } rcr_boot_type;
    typedef enum logic [2:0] {
        SEL_NONE, SEL_REMAP, SEL_STATUS, SEL_CLEAR, SEL_IRQ_ST, SEL_MASK
    } rcr_sel_type;
endpackage

// *** hdl/rcr_reset_remap.sv ***
// Reset cause recording, reset sequencing and memory remap control
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
module rcr_reset_remap #(
    parameter logic FLASH_SMALL = 1'b0,
    parameter logic SRAM_SMALL = 1'b0
) (
    // Clock and power-on reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Reset sources and pins
    input wire logic wdt_timeout,
    input wire logic ext_reset_pin_n,
    input wire logic boot_mode_pin,
    // Core fetch address and memory mapping
    input wire logic [31:0] fetch_addr,
    output logic sram_at_zero,
    output logic vec_from_sram,
    // Boot, chip reset and interrupt
    output logic sys_reset_n,
    output logic kernel_active,
    output logic core_start,
    output logic [31:0] boot_vector,
    output logic irq
);
    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic rcr_pkg::rcr_sel_type sel(input logic [31:0] a);
        case (a)
            rcr_pkg::REMAP_ADDR: sel = rcr_pkg::SEL_REMAP;
            rcr_pkg::STATUS_ADDR: sel = rcr_pkg::SEL_STATUS;
            rcr_pkg::CLEAR_ADDR: sel = rcr_pkg::SEL_CLEAR;
            rcr_pkg::IRQ_STATUS_ADDR: sel = rcr_pkg::SEL_IRQ_ST;
            rcr_pkg::IRQ_MASK_ADDR: sel = rcr_pkg::SEL_MASK;
            default: sel = rcr_pkg::SEL_NONE;
        endcase
    endfunction

    logic aw_held, w_held, next_aw_held, next_w_held;
    logic [31:0] aw_addr, w_data, next_aw_addr, next_w_data;
    logic w_lane0, next_w_lane0;
    logic next_awready, next_wready, next_bvalid, next_arready;
    logic next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic wr_fire, wr_en;
    rcr_pkg::rcr_sel_type wsel;
    logic remap, next_remap;
    logic [2:0] status, next_status, clear_reg, next_clear;
    logic [2:0] irq_st, next_irq_st, irq_mask, next_irq_mask;
    logic next_irq, next_sram_at_zero, next_vec_from_sram;
    logic ext_s1, ext_s2, ext_prev, boot_s1, boot_s2;
    logic ext_fall, sw_req, rst_evt;
    logic [7:0] hold_cnt, next_hold_cnt, kcnt, next_kcnt;
    rcr_pkg::rcr_boot_type state, next_state;
    logic next_sys_reset_n, next_kernel_active, next_core_start;
    logic [31:0] next_boot_vector;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Both pins are asynchronous; the second stage is used, and a third stage of the reset pin finds its falling edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_s1 <= 1'b1;
            ext_s2 <= 1'b1;
            ext_prev <= 1'b1;
            boot_s1 <= 1'b0;
            boot_s2 <= 1'b0;
        end else begin
            ext_s1 <= ext_reset_pin_n;
            ext_s2 <= ext_s1;
            ext_prev <= ext_s2;
            boot_s1 <= boot_mode_pin;
            boot_s2 <= boot_s1;
        end
    end

    // Reset events seen by this block
    assign ext_fall = ext_prev & ~ext_s2;
    assign wsel = sel(aw_addr);
    assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
    assign wr_en = wr_fire & w_lane0;
    assign sw_req = wr_en & (wsel == rcr_pkg::SEL_STATUS)
        & w_data[rcr_pkg::SW_BIT];
    assign rst_evt = wdt_timeout | ext_fall | sw_req;

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    // One write and one read in flight; answer one cycle after both
    always_comb begin
        next_aw_held = aw_held ? ~wr_fire
            : (s_axi_awvalid & s_axi_awready);
        next_w_held = w_held ? ~wr_fire : (s_axi_wvalid & s_axi_wready);
        next_aw_addr = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr
            : aw_addr;
        next_w_data = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : w_data;
        next_w_lane0 = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb[0]
            : w_lane0;
        next_bvalid = wr_fire | (s_axi_bvalid & ~s_axi_bready);
        next_bresp = wr_fire ? ((wsel == rcr_pkg::SEL_NONE)
            ? rcr_pkg::RESP_SLVERR : rcr_pkg::RESP_OKAY) : s_axi_bresp;
        next_awready = ~next_aw_held & ~next_bvalid;
        next_wready = ~next_w_held & ~next_bvalid;
        next_rvalid = (s_axi_arvalid & s_axi_arready)
            | (s_axi_rvalid & ~s_axi_rready);
        next_arready = ~next_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_arvalid & s_axi_arready) begin
            next_rresp = rcr_pkg::RESP_OKAY;
            // Reserved bits read as zero
            case (sel(s_axi_araddr))
                rcr_pkg::SEL_REMAP: begin
                    next_rdata = 32'h0;
                    next_rdata[rcr_pkg::REMAP_BIT] = remap;
                    next_rdata[rcr_pkg::SRAM_SMALL_BIT] = SRAM_SMALL;
                    next_rdata[rcr_pkg::FLASH_SMALL_BIT] = FLASH_SMALL;
                end
                rcr_pkg::SEL_STATUS: next_rdata = {29'h0, status};
                rcr_pkg::SEL_CLEAR: next_rdata = {29'h0, clear_reg};
                rcr_pkg::SEL_IRQ_ST: next_rdata = {29'h0, irq_st};
                rcr_pkg::SEL_MASK: next_rdata = {29'h0, irq_mask};
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = rcr_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 32'h0;
            w_data <= 32'h0;
            w_lane0 <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_lane0 <= next_w_lane0;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // ------------------------------------------------------------
    // Registers, remap and interrupts
    // ------------------------------------------------------------
    // Hardware sets are applied after clears so an event is never lost
    always_comb begin
        next_remap = remap;
        next_status = status;
        next_clear = clear_reg;
        next_irq_st = irq_st;
        next_irq_mask = irq_mask;
        if (wr_en) begin
            case (wsel)
                rcr_pkg::SEL_REMAP:
                    next_remap = w_data[rcr_pkg::REMAP_BIT];
                rcr_pkg::SEL_CLEAR: begin
                    next_clear = w_data[2:0];
                    next_status = status & ~w_data[2:0];
                end
                rcr_pkg::SEL_IRQ_ST: next_irq_st = irq_st & ~w_data[2:0];
                rcr_pkg::SEL_MASK: next_irq_mask = w_data[2:0];
                default: next_remap = remap;
            endcase
        end
        // Any reset, or the chip held in reset, maps program memory
        if (rst_evt || state == rcr_pkg::BOOT_RESET)
            next_remap = rcr_pkg::REMAP_RESET;
        // External reset touches no status flag; others survive their own reset
        if (wdt_timeout)
            next_status[rcr_pkg::WDT_BIT] = 1'b1;
        if (sw_req)
            next_status[rcr_pkg::SW_BIT] = 1'b1;
        if (wdt_timeout)
            next_irq_st[rcr_pkg::IRQ_WDT_BIT] = 1'b1;
        if (ext_fall)
            next_irq_st[rcr_pkg::IRQ_EXT_BIT] = 1'b1;
        if (next_core_start)
            next_irq_st[rcr_pkg::IRQ_BOOT_BIT] = 1'b1;
        next_irq = |(next_irq_st & next_irq_mask);
        next_sram_at_zero = next_remap;
        next_vec_from_sram = next_remap
            & (fetch_addr <= rcr_pkg::VECTOR_TOP);
    end

    // Only power-on clears the cause flags to their reset value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            remap <= rcr_pkg::REMAP_RESET;
            status <= rcr_pkg::STATUS_RESET;
            clear_reg <= rcr_pkg::CLEAR_RESET;
            irq_st <= rcr_pkg::IRQ_RESET;
            irq_mask <= rcr_pkg::IRQ_RESET;
            irq <= 1'b0;
            sram_at_zero <= rcr_pkg::REMAP_RESET;
            vec_from_sram <= 1'b0;
        end else begin
            remap <= next_remap;
            status <= next_status;
            clear_reg <= next_clear;
            irq_st <= next_irq_st;
            irq_mask <= next_irq_mask;
            irq <= next_irq;
            sram_at_zero <= next_sram_at_zero;
            vec_from_sram <= next_vec_from_sram;
        end
    end

    // ------------------------------------------------------------
    // Reset pulse and boot sequence
    // ------------------------------------------------------------
    // Kernel runs first; a low boot pin leaves it in download mode
    always_comb begin
        next_state = state;
        next_kcnt = kcnt;
        next_core_start = 1'b0;
        next_boot_vector = boot_vector;
        next_hold_cnt = (hold_cnt != 8'h0) ? hold_cnt - 8'h1 : hold_cnt;
        if (rst_evt) begin
            next_hold_cnt = 8'(rcr_pkg::RESET_HOLD_CYCLES);
            next_state = rcr_pkg::BOOT_RESET;
        end else begin
            case (state)
                rcr_pkg::BOOT_RESET:
                    if (next_hold_cnt == 8'h0) begin
                        next_state = rcr_pkg::BOOT_KERNEL;
                        next_kcnt = 8'(rcr_pkg::KERNEL_CYCLES);
                    end
                rcr_pkg::BOOT_KERNEL:
                    if (kcnt > 8'h1) begin
                        next_kcnt = kcnt - 8'h1;
                    end else if (boot_s2) begin
                        next_kcnt = 8'h0;
                        next_state = rcr_pkg::BOOT_USER;
                        next_core_start = 1'b1;
                        next_boot_vector = rcr_pkg::RESET_VECTOR;
                    end else begin
                        next_kcnt = 8'h0;
                        next_state = rcr_pkg::BOOT_DOWNLOAD;
                    end
                default: next_kcnt = kcnt;
            endcase
        end
        next_sys_reset_n = (next_state != rcr_pkg::BOOT_RESET);
        next_kernel_active = (next_state == rcr_pkg::BOOT_KERNEL)
            | (next_state == rcr_pkg::BOOT_DOWNLOAD);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= rcr_pkg::BOOT_RESET;
            hold_cnt <= 8'(rcr_pkg::RESET_HOLD_CYCLES);
            kcnt <= 8'h0;
            sys_reset_n <= 1'b0;
            kernel_active <= 1'b0;
            core_start <= 1'b0;
            boot_vector <= 32'h0;
        end else begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
            kcnt <= next_kcnt;
            sys_reset_n <= next_sys_reset_n;
            kernel_active <= next_kernel_active;
            core_start <= next_core_start;
            boot_vector <= next_boot_vector;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_reset_unmaps;
        @(posedge aclk) disable iff (!aresetn)
        rst_evt |=> !sram_at_zero && !sys_reset_n;
    endproperty
    a_reset_unmaps: assert property (p_reset_unmaps)
        else $error("remap not cleared by reset");

    property p_remap_set;
        @(posedge aclk) disable iff (!aresetn)
        wr_en && wsel == rcr_pkg::SEL_REMAP && w_data[0] && !rst_evt
            && state != rcr_pkg::BOOT_RESET |=> sram_at_zero;
    endproperty
    a_remap_set: assert property (p_remap_set)
        else $error("remap set not applied");

    property p_remap_clr;
        @(posedge aclk) disable iff (!aresetn)
        wr_en && wsel == rcr_pkg::SEL_REMAP && !w_data[0] |=> !sram_at_zero;
    endproperty
    a_remap_clr: assert property (p_remap_clr)
        else $error("remap clear not applied");

    property p_vec_region;
        @(posedge aclk) disable iff (!aresetn)
        vec_from_sram |-> sram_at_zero
            && $past(fetch_addr) <= rcr_pkg::VECTOR_TOP;
    endproperty
    a_vec_region: assert property (p_vec_region)
        else $error("vector fetch outside mirrored region");

    property p_boot_branch;
        @(posedge aclk) disable iff (!aresetn)
        core_start |-> $past(kernel_active) && $past(boot_s2)
            && boot_vector == rcr_pkg::RESET_VECTOR;
    endproperty
    a_boot_branch: assert property (p_boot_branch)
        else $error("branch without kernel or boot pin");

    property p_wdt_flag;
        @(posedge aclk) disable iff (!aresetn)
        wdt_timeout |=> status[rcr_pkg::WDT_BIT];
    endproperty
    a_wdt_flag: assert property (p_wdt_flag)
        else $error("watchdog flag not set");

    property p_sw_reset;
        @(posedge aclk) disable iff (!aresetn)
        sw_req |=> status[rcr_pkg::SW_BIT] && !sys_reset_n;
    endproperty
    a_sw_reset: assert property (p_sw_reset)
        else $error("software reset not taken");

    property p_clear_only;
        @(posedge aclk) disable iff (!aresetn)
        |($past(status) & ~status) |-> $past(wr_en)
            && $past(wsel) == rcr_pkg::SEL_CLEAR;
    endproperty
    a_clear_only: assert property (p_clear_only)
        else $error("status flag fell without clear write");

    property p_ext_keeps;
        @(posedge aclk) disable iff (!aresetn)
        ext_fall && !wdt_timeout && !wr_en |=> status == $past(status);
    endproperty
    a_ext_keeps: assert property (p_ext_keeps)
        else $error("external reset changed status");

    property p_irq_level;
        @(posedge aclk) disable iff (!aresetn)
        irq == |(irq_st & irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt disagrees with status and mask");
endmodule

// *** verif/rcr_core_model.sv ***
// Processor core model: AXI4-Lite master on the register side
`timescale 1ns/1ps
module rcr_core_model (
    // Clock
    input wire logic aclk,
    // Write channels
    output logic [31:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // Read channels
    output logic [31:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // Idle bus from time zero
    initial begin
        s_axi_awaddr = 32'h00000000;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 32'h00000000;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
    end

    // Each channel is judged at the rising edge on the values it samples;
    // a channel is released only right after the edge that took it
    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      output logic [1:0] resp);
        logic b_hs;
        b_hs = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_hs) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            b_hs = s_axi_bvalid && s_axi_bready;
            resp = s_axi_bresp;
        end
        s_axi_bready <= 1'b0;
    endtask

    // Read one word; data and response taken at the edge rvalid is seen
    task automatic rd(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] resp);
        logic r_hs;
        r_hs = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_hs) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            r_hs = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            resp = s_axi_rresp;
        end
        s_axi_rready <= 1'b0;
    endtask
endmodule

// *** verif/reset_cause_and_remap_test.sv ***
// Self-checking testbench for the reset cause and memory remap block
`timescale 1ns/1ps
module reset_cause_and_remap_test;
    typedef struct {
        logic [31:0] wa, wd, ra, rexp;
        logic [1:0] bexp, rexp_resp;
    } rcr_row_type;
    localparam logic [31:0] RMP = rcr_pkg::REMAP_ADDR;
    localparam logic [31:0] STA = rcr_pkg::STATUS_ADDR;
    localparam logic [31:0] CLR = rcr_pkg::CLEAR_ADDR;
    localparam logic [31:0] NOREG = 32'hFFFF0238;
    localparam logic [1:0] OK = rcr_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = rcr_pkg::RESP_SLVERR;
    logic aclk, aresetn, wdt_timeout, ext_reset_pin_n, boot_mode_pin;
    logic [31:0] awaddr, wdata, araddr, rdata, fetch_addr, boot_vector, data;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, started;
    logic sram_at_zero, vec_from_sram, sys_reset_n, kernel_active;
    logic core_start, irq;
    int failures = 0;
    int tests_run = 0;
    // Flash small, SRAM full: a swapped pair of read-only bits shows up
    rcr_reset_remap #(.FLASH_SMALL(1'b1), .SRAM_SMALL(1'b0)) uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .wdt_timeout(wdt_timeout), .ext_reset_pin_n(ext_reset_pin_n),
        .boot_mode_pin(boot_mode_pin), .fetch_addr(fetch_addr),
        .sram_at_zero(sram_at_zero), .vec_from_sram(vec_from_sram),
        .sys_reset_n(sys_reset_n), .kernel_active(kernel_active),
        .core_start(core_start), .boot_vector(boot_vector), .irq(irq));
    rcr_core_model core (
        .aclk(aclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // Clock at 100 MHz
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // One comparison, counted
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        core.rd(a, data, resp);
        chk("register read", exp, data);
    endtask

    // Let registered outputs follow the last input change
    task automatic settle;
        repeat (2) @(posedge aclk);
        #1;
    endtask

    // Watch one reset sequence up to the branch out of the kernel
    task automatic boot_wait(output logic st);
        logic held;
        logic kern;
        held = 1'b0;
        kern = 1'b0;
        st = 1'b0;
        for (int i = 0; i < 60 && !st; i++) begin
            @(posedge aclk);
            #1;
            held = held | !sys_reset_n;
            kern = kern | kernel_active;
            st = core_start;
            if (st) chk("boot_vector", 32'h00000000, boot_vector);
        end
        chk("chip reset seen", 32'h1, {31'h0, held});
        chk("kernel ran", 32'h1, {31'h0, kern});
    endtask

    task automatic pulse_wdt;
        @(posedge aclk);
        wdt_timeout <= 1'b1;
        @(posedge aclk);
        wdt_timeout <= 1'b0;
    endtask

    // Verdict, reached by the main sequence or by the watchdog
    task automatic final_report;
        $display("Checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watchdog: the whole run needs a few hundred cycles
    initial begin
        #200000;
        failures++;
        final_report();
    end

    // Main sequence
    initial begin
        rcr_row_type rows[6] = '{
            '{RMP, 32'h00000001, RMP, 32'h00000011, OK, OK},
            '{RMP, 32'h000000FF, RMP, 32'h00000011, OK, OK},
            '{RMP, 32'h00000000, RMP, 32'h00000010, OK, OK},
            '{STA, 32'h00000000, STA, 32'h00000001, OK, OK},
            '{CLR, 32'h00000001, STA, 32'h00000000, OK, OK},
            '{NOREG, 32'h00000001, NOREG, 32'h00000000, ERR, ERR}};
        aresetn = 1'b0;
        wdt_timeout = 1'b0;
        ext_reset_pin_n = 1'b1;
        boot_mode_pin = 1'b1;
        fetch_addr = 32'h00080100;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        boot_wait(started);
        chk("power-on branch", 32'h1, {31'h0, started});
        rd_chk(STA, 32'h00000001);
        rd_chk(RMP, 32'h00000010);
        // Table of ordinary write/read pairs
        foreach (rows[i]) begin
            core.wr(rows[i].wa, rows[i].wd, resp);
            chk("bresp", {30'h0, rows[i].bexp}, {30'h0, resp});
            core.rd(rows[i].ra, data, resp);
            chk("rdata", rows[i].rexp, data);
            chk("rresp", {30'h0, rows[i].rexp_resp}, {30'h0, resp});
        end
        // SRAM at zero and vector fetches around the 0x20 boundary
        core.wr(RMP, 32'h00000001, resp);
        core.wr(rcr_pkg::IRQ_MASK_ADDR, 32'h00000001, resp);
        settle();
        chk("sram_at_zero", 32'h1, {31'h0, sram_at_zero});
        @(posedge aclk) fetch_addr <= 32'h00000020;
        settle();
        chk("vec_from_sram", 32'h1, {31'h0, vec_from_sram});
        @(posedge aclk) fetch_addr <= 32'h00000024;
        settle();
        chk("vec_from_sram", 32'h0, {31'h0, vec_from_sram});
        @(posedge aclk) fetch_addr <= 32'h00080100;
        // Watchdog reset undoes the remap and records its cause
        pulse_wdt();
        boot_wait(started);
        chk("sram_at_zero", 32'h0, {31'h0, sram_at_zero});
        rd_chk(RMP, 32'h00000010);
        rd_chk(STA, 32'h00000002);
        chk("irq", 32'h1, {31'h0, irq});
        core.wr(rcr_pkg::IRQ_STATUS_ADDR, 32'h00000001, resp);
        settle();
        chk("irq", 32'h0, {31'h0, irq});
        // Software forced reset keeps the earlier cause too
        core.wr(STA, 32'h00000004, resp);
        boot_wait(started);
        rd_chk(STA, 32'h00000006);
        core.wr(CLR, 32'h00000007, resp);
        rd_chk(STA, 32'h00000000);
        rd_chk(CLR, 32'h00000007);
        // External pin reset leaves the flags at zero
        @(posedge aclk);
        ext_reset_pin_n <= 1'b0;
        repeat (3) @(posedge aclk);
        ext_reset_pin_n <= 1'b1;
        boot_wait(started);
        rd_chk(STA, 32'h00000000);
        // Boot pin low: the kernel never branches to user code
        boot_mode_pin <= 1'b0;
        pulse_wdt();
        boot_wait(started);
        chk("no branch", 32'h0, {31'h0, started});
        chk("kernel_active", 32'h1, {31'h0, kernel_active});
        // Power-on mid-run: watchdog cause gives way to power-on alone
        @(posedge aclk) aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        boot_wait(started);
        rd_chk(STA, 32'h00000001);
        final_report();
    end
endmodule
